// file: rtl/pllp_pkg.sv
// Package for the synthesizer latch bank: select codes, field layouts, timing counts
package pllp_pkg;

    // Word length and latch select codes held in the two lowest bits
    localparam int WORD_W = 24;
    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_RDIV = 2'h1;
    localparam logic [1:0] SEL_NDIV = 2'h2;
    localparam logic [1:0] SEL_TEST = 2'h3;

    // Reset value of every latch and reference edges before synchronous power-down
    localparam logic [WORD_W-1:0] LATCH_RST = 24'h000000;
    localparam logic [1:0] SYNC_PD_EDGES = 2'h2;

    // Control latch, top bit first
    typedef struct packed {
        logic prescaler_sel_high;
        logic prescaler_sel_low;
        logic powerdown_sync_sel;
        logic powerdown_request;
        logic [2:0] pump_current_two;
        logic [2:0] pump_current_one;
        logic [1:0] output_level;
        logic mute_until_locked;
        logic pump_gain_sel;
        logic pump_three_state;
        logic detector_polarity;
        logic [2:0] observe_mux_sel;
        logic divider_reset_bit;
        logic [1:0] core_current;
        logic latch_select_high;
        logic latch_select_low;
    } pllp_ctrl_t;

    // Feedback divider latch, main count at 20:8
    typedef struct packed {
        logic halved_feedback_sel;
        logic half_rate_output;
        logic pump_gain_sel;
        logic [12:0] main_count;
        logic spare_bit;
        logic [4:0] swallow_count;
        logic latch_select_high;
        logic latch_select_low;
    } pllp_ndiv_t;

    // Reference divider latch, reference count at 15:2
    typedef struct packed {
        logic [1:0] spare_bits;
        logic [1:0] band_clock_div;
        logic factory_test_flag;
        logic lock_precision_sel;
        logic [1:0] antibacklash_width;
        logic [13:0] ref_count;
        logic latch_select_high;
        logic latch_select_low;
    } pllp_rdiv_t;

    // Power state, one-hot
    typedef enum logic [3:0] {
        PS_UNPOWERED = 4'b0001,
        PS_ACTIVE = 4'b0010,
        PS_SYNC_WAIT = 4'b0100,
        PS_DOWN = 4'b1000
    } pllp_pstate_t;

endpackage : pllp_pkg

// file: rtl/pllp_latch_bank.sv
// Serial-loaded latch bank with power-down control of the synthesizer
// Function
// R1: Words are 24 bits, MSB first on serial clock rises, moved on strobe rise.
// R2: Select bits both zero store the word in the control latch.
// R3: Select high-low goes to feedback divider latch, low-high to reference latch.
// R4: Feedback latch main count sits at bits 20 down to 8.
// R5: Control latch field positions as laid out in the control struct.
// R6: The two top control bits select the prescaler modulus.
// R7: Host writes reference latch, then control latch, then feedback latch after power-up.
// R8: First control latch load leaves the unpowered state and starts bias.
// R9: Host waits 5 ms or 600 us between control and feedback writes.
// R10: Control bits 21 and 20 are power-down mode and request.
// R11: Request set with mode clear powers down at once on load.
// R12: Both set powers down on second reference edge after the strobe.
// R13: Chip enable low disables the device whatever the power-down bits hold.
// R14: Power-down forces reference, main and timeout dividers to load state.
// R15: Power-down places the charge pump in three-state.
// R16: Entering power-down clears the digital lock detect.
// R17: Power-down debiases RF outputs and disables the reference buffer.
// R18: Shifting and latch loads continue while powered down.
// R19: Host avoids feedback writes in power-down, else repeats full sequence.
// R20: With feedback latch unchanged, power-up keeps the chosen band.
// R21: Reference latch holds count at 15:2 with its control bits above.
`timescale 1ns/1ns
module pllp_latch_bank
    import pllp_pkg::*;
(
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Serial programming link
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic latch_load_strobe,
    // Hardware control and reference divider output
    input wire logic chip_enable,
    input wire logic ref_div_out,
    // Latch contents
    output pllp_ctrl_t ctrl_latch,
    output pllp_ndiv_t ndiv_latch,
    output pllp_rdiv_t rdiv_latch,
    output logic [1:0] prescaler_mode,
    output logic pump_gain_eff,
    // Power-down effects
    output logic powered_down,
    output logic bias_enable,
    output logic divider_hold,
    output logic pump_tristate,
    output logic lock_detect_clear,
    output logic rf_bias_enable,
    output logic ref_buffer_enable,
    output logic band_select_start
);

    logic ser_clk_q;
    logic le_q;
    logic ref_q;
    logic [WORD_W-1:0] shift_r;
    pllp_pstate_t pstate_r;
    logic [1:0] sync_cnt_r;
    logic n_dirty_r;
    logic ser_rise;
    logic le_rise;
    logic ref_rise;
    logic [1:0] word_sel;
    logic pd_now;
    pllp_ctrl_t new_ctrl;

    // Pins are synchronous to clk_sys, so one flop each gives the edge history
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ser_clk_q <= 1'b0;
            le_q <= 1'b0;
            ref_q <= 1'b0;
        end else if (clk_en) begin
            ser_clk_q <= ser_clk;
            le_q <= latch_load_strobe;
            ref_q <= ref_div_out;
        end
    end

    assign ser_rise = ser_clk & ~ser_clk_q;
    assign le_rise = latch_load_strobe & ~le_q;
    assign ref_rise = ref_div_out & ~ref_q;
    // R2: select bits are the two LSBs of the shifted word
    assign word_sel = shift_r[1:0];
    // R5: control fields through struct
    assign new_ctrl = pllp_ctrl_t'(shift_r);

    // R1: MSB first shift; R18: keeps running in every power state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= LATCH_RST;
        end else if (clk_en && ser_rise) begin
            shift_r <= {shift_r[WORD_W-2:0], ser_data};
        end
    end

    // R2: control latch load on strobe rise; R18: also during power-down
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_latch <= pllp_ctrl_t'(LATCH_RST);
        end else if (clk_en && le_rise && word_sel == SEL_CTRL) begin
            ctrl_latch <= new_ctrl;
        end
    end

    // R3: feedback divider latch; R4: main count lands at 20:8 through the struct
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ndiv_latch <= pllp_ndiv_t'(LATCH_RST);
        end else if (clk_en && le_rise && word_sel == SEL_NDIV) begin
            ndiv_latch <= pllp_ndiv_t'(shift_r);
        end
    end

    // R3: reference divider latch; R21: layout from the struct
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdiv_latch <= pllp_rdiv_t'(LATCH_RST);
        end else if (clk_en && le_rise && word_sel == SEL_RDIV) begin
            rdiv_latch <= pllp_rdiv_t'(shift_r);
        end
    end
    // Factory test latch words (SEL_TEST) are dropped on purpose

    // R6: prescaler mode from the top control bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prescaler_mode <= 2'h0;
        end else if (clk_en && le_rise && word_sel == SEL_CTRL) begin
            prescaler_mode <= {new_ctrl.prescaler_sel_high, new_ctrl.prescaler_sel_low};
        end
    end

    // R5: pump gain at bit 10
    // Pump gain is shared by two latches; the latest write of either wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pump_gain_eff <= 1'b0;
        end else if (clk_en && le_rise && (word_sel == SEL_CTRL || word_sel == SEL_NDIV)) begin
            pump_gain_eff <= shift_r[word_sel == SEL_CTRL ? 10 : 21];
        end
    end

    // Power state machine
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pstate_r <= PS_UNPOWERED;
        end else if (clk_en) begin
            case (pstate_r)
                PS_UNPOWERED, PS_ACTIVE, PS_SYNC_WAIT, PS_DOWN: begin
                    if (le_rise && word_sel == SEL_CTRL) begin
                        // R10: bit 20 requests, bit 21 picks synchronous mode
                        if (new_ctrl.powerdown_request && !new_ctrl.powerdown_sync_sel) begin
                            // R11: asynchronous power-down takes effect on load
                            pstate_r <= PS_DOWN;
                        end else if (new_ctrl.powerdown_request) begin
                            // R12: synchronous mode waits for reference edges
                            pstate_r <= (pstate_r == PS_DOWN) ? PS_DOWN : PS_SYNC_WAIT;
                        end else begin
                            // R8: control load starts the bias circuitry
                            pstate_r <= PS_ACTIVE;
                        end
                    end else if (pstate_r == PS_SYNC_WAIT && ref_rise && sync_cnt_r == SYNC_PD_EDGES - 2'h1) begin
                        // R12: second reference rise after the strobe
                        pstate_r <= PS_DOWN;
                    end
                end
                default: begin
                    pstate_r <= PS_UNPOWERED;
                end
            endcase
        end
    end

    // R12: counts reference rises after the strobe, cleared on each new load
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_cnt_r <= 2'h0;
        end else if (clk_en) begin
            if (le_rise) begin
                sync_cnt_r <= 2'h0;
            end else if (pstate_r == PS_SYNC_WAIT && ref_rise) begin
                sync_cnt_r <= sync_cnt_r + 2'h1;
            end
        end
    end

    // R13: chip enable low overrides whatever software asked for
    assign pd_now = !chip_enable || pstate_r == PS_DOWN || pstate_r == PS_UNPOWERED;

    // Power-down effects, all registered so outputs come from flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            powered_down <= 1'b1;
            bias_enable <= 1'b0;
            divider_hold <= 1'b1;
            pump_tristate <= 1'b1;
            lock_detect_clear <= 1'b0;
            rf_bias_enable <= 1'b0;
            ref_buffer_enable <= 1'b0;
        end else if (clk_en) begin
            powered_down <= pd_now;
            bias_enable <= !pd_now;
            // R14: dividers held in load state, or by the counter reset bit
            divider_hold <= pd_now || ctrl_latch.divider_reset_bit;
            // R15: pump three-state in power-down or when software asks
            pump_tristate <= pd_now || ctrl_latch.pump_three_state;
            // R16: one-cycle clear on entry to power-down
            lock_detect_clear <= pd_now && !powered_down;
            // R17: RF outputs debiased and reference buffer off
            rf_bias_enable <= !pd_now;
            ref_buffer_enable <= !pd_now;
        end
    end

    // R20: band is kept unless the feedback latch was written while down
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            n_dirty_r <= 1'b0;
            band_select_start <= 1'b0;
        end else if (clk_en) begin
            band_select_start <= 1'b0;
            if (le_rise && word_sel == SEL_NDIV && !pd_now) begin
                band_select_start <= 1'b1;
                n_dirty_r <= 1'b0;
            end else if (le_rise && word_sel == SEL_NDIV) begin
                n_dirty_r <= 1'b1;
            end else if (!pd_now && powered_down && n_dirty_r) begin
                band_select_start <= 1'b1;
                n_dirty_r <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_ctrl_load: assert property (clk_en && le_rise && word_sel == SEL_CTRL |=> ctrl_latch == $past(shift_r)) // R2
        else $error("control latch did not take the shifted word");
    a_ndiv_load: assert property (clk_en && le_rise && word_sel == SEL_NDIV |=> ndiv_latch.main_count == $past(shift_r[20:8])) // R4
        else $error("main count not at bits 20 to 8");
    a_rdiv_load: assert property (clk_en && le_rise && word_sel == SEL_RDIV |=> rdiv_latch == $past(shift_r)) // R3
        else $error("reference latch did not take the word");
    a_shift_msb: assert property (clk_en && ser_rise |=> shift_r[0] == $past(ser_data) && shift_r[23:1] == $past(shift_r[22:0])) // R1
        else $error("shift register did not shift in order");
    a_async_down: assert property (clk_en && le_rise && word_sel == SEL_CTRL && shift_r[20] && !shift_r[21] |=> pstate_r == PS_DOWN) // R11
        else $error("asynchronous power-down not immediate");
    a_sync_wait: assert property (clk_en && le_rise && word_sel == SEL_CTRL && shift_r[21:20] == 2'h3 && pstate_r != PS_DOWN |=> pstate_r == PS_SYNC_WAIT) // R12
        else $error("synchronous power-down did not wait");
    a_ce_off: assert property (clk_en && !chip_enable |=> powered_down && !rf_bias_enable && !ref_buffer_enable) // R13
        else $error("chip enable low did not disable device");
    a_pd_effects: assert property (powered_down |-> pump_tristate && divider_hold && !bias_enable) // R15
        else $error("power-down effects missing");
    a_lock_clear: assert property (clk_en && pd_now && !powered_down |=> lock_detect_clear ##1 !lock_detect_clear || !clk_en) // R16
        else $error("lock detect clear not a single pulse on entry");
    a_wake_ctrl: assert property (clk_en && chip_enable && le_rise && word_sel == SEL_CTRL && !shift_r[20] |=> ##1 !powered_down || !clk_en) // R8
        else $error("control load did not power up");

    c_sync_down: cover property (pstate_r == PS_SYNC_WAIT ##[1:200] pstate_r == PS_DOWN);
    c_wake: cover property (pstate_r == PS_UNPOWERED ##[1:300] pstate_r == PS_ACTIVE);
    c_band_redo: cover property (n_dirty_r ##[1:300] band_select_start);
    c_ce_drop: cover property (pstate_r == PS_ACTIVE && !chip_enable);

endmodule : pllp_latch_bank

// file: sim/pllp_host_model.sv
// Host side of the three-wire programming link
`timescale 1ns/1ns
module pllp_host_model
    import pllp_pkg::*;
#(
    parameter int SETTLE_CYC = 60000
)
(
    // System
    input wire logic clk_sys,
    // Serial link
    output logic ser_clk,
    output logic ser_data,
    output logic latch_load_strobe
);
    // Link idles with the clock and strobe low
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        latch_load_strobe = 1'b0;
    end

    task automatic send_word(input logic [WORD_W-1:0] w);
        for (int i = WORD_W - 1; i >= 0; i--) begin
            @(posedge clk_sys);
            #1;
            ser_data = w[i];
            ser_clk = 1'b1;
            @(posedge clk_sys);
            #1;
            ser_clk = 1'b0;
        end
        // Idle data is not held, so a stale bit can never pass for a good one
        ser_data = ~w[0];
        @(posedge clk_sys);
        #1;
        latch_load_strobe = 1'b1;
        @(posedge clk_sys);
        #1;
        latch_load_strobe = 1'b0;
    endtask : send_word

    task automatic program_sequence(input logic [WORD_W-1:0] r, input logic [WORD_W-1:0] c,
                                    input logic [WORD_W-1:0] n);
        send_word(r);
        send_word(c);
        // Bias must settle before band selection runs on the feedback load
        repeat (SETTLE_CYC) @(posedge clk_sys);
        send_word(n);
    endtask : program_sequence
endmodule : pllp_host_model

// file: sim/testbench.sv
// Self-checking bench for the synthesizer latch bank
`timescale 1ns/1ns
module testbench;
    import pllp_pkg::*;
    // Design signals
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic chip_enable = 1'b1;
    logic ref_div_out = 1'b0;
    logic clk_en = 1'b1;
    logic ser_clk, ser_data, latch_load_strobe;
    pllp_ctrl_t ctrl_latch;
    pllp_ndiv_t ndiv_latch;
    pllp_rdiv_t rdiv_latch;
    logic [1:0] prescaler_mode;
    logic pump_gain_eff, powered_down, bias_enable, divider_hold, pump_tristate;
    logic lock_detect_clear, rf_bias_enable, ref_buffer_enable, band_select_start;
    // Bench state: shadow latches indexed by select code, pulse counters
    int err_total = 0;
    int check_count = 0;
    int ldc_cnt = 0;
    int bss_cnt = 0;
    int b;
    logic [23:0] sh [4];
    logic sh_pg;
    logic [23:0] rows [6] = '{24'h00fffd, 24'hcfa3f0, 24'h1fff02, 24'he00302, 24'h5a5a5b, 24'h400400};

    // Clock, 100 MHz
    always #5 clk_sys = ~clk_sys;

    // Count one-cycle pulses at the falling edge, where the outputs have settled
    always @(negedge clk_sys) begin
        ldc_cnt += int'(lock_detect_clear === 1'b1);
        bss_cnt += int'(band_select_start === 1'b1);
    end

    pllp_latch_bank u_pllp_latch_bank (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .ser_clk(ser_clk),
        .ser_data(ser_data), .latch_load_strobe(latch_load_strobe), .chip_enable(chip_enable),
        .ref_div_out(ref_div_out), .ctrl_latch(ctrl_latch), .ndiv_latch(ndiv_latch), .rdiv_latch(rdiv_latch),
        .prescaler_mode(prescaler_mode), .pump_gain_eff(pump_gain_eff), .powered_down(powered_down),
        .bias_enable(bias_enable), .divider_hold(divider_hold), .pump_tristate(pump_tristate),
        .lock_detect_clear(lock_detect_clear), .rf_bias_enable(rf_bias_enable),
        .ref_buffer_enable(ref_buffer_enable), .band_select_start(band_select_start));

    pllp_host_model #(.SETTLE_CYC(60000)) u_pllp_host_model (.clk_sys(clk_sys), .ser_clk(ser_clk),
        .ser_data(ser_data), .latch_load_strobe(latch_load_strobe));

    // Compare and count
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    // Bounded wait for the power state, a miss counts as a mismatch
    task automatic wait_pd(input logic v, input int n);
        for (int i = 0; i < n; i++) begin
            if (powered_down === v) break;
            @(posedge clk_sys);
            #1;
        end
        chk({23'h0, powered_down}, {23'h0, v}, "power state");
    endtask : wait_pd

    // One reference divider pulse
    task automatic ref_pulse;
        @(posedge clk_sys);
        #1;
        ref_div_out = 1'b1;
        @(posedge clk_sys);
        #1;
        ref_div_out = 1'b0;
    endtask : ref_pulse

    // Verdict
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        chk({23'h0, powered_down}, 24'h1, "unpowered after reset");
        u_pllp_host_model.program_sequence(24'h000009, 24'h8f0000, 24'h000a02);
        wait_pd(1'b0, 3);
        chk({23'h0, bias_enable}, 24'h1, "bias on");
        // The pulse counters lag one falling edge behind the outputs
        repeat (2) @(posedge clk_sys);
        #1;
        chk(24'(bss_cnt), 24'h1, "band select on feedback load");
        sh[1] = 24'h000009;
        sh[0] = 24'h8f0000;
        sh[2] = 24'h000a02;
        sh_pg = 1'b0;
        // Table rows: route by select code, test select leaves all latches alone
        foreach (rows[k]) begin
            u_pllp_host_model.send_word(rows[k]);
            if (rows[k][1:0] != SEL_TEST) sh[rows[k][1:0]] = rows[k];
            if (rows[k][1:0] == SEL_CTRL) sh_pg = rows[k][10];
            if (rows[k][1:0] == SEL_NDIV) sh_pg = rows[k][21];
            chk(ctrl_latch, sh[0], "control latch");
            chk(ndiv_latch, sh[2], "feedback latch");
            chk(rdiv_latch, sh[1], "reference latch");
            chk(24'(ndiv_latch.main_count), 24'(sh[2][20:8]), "main count");
            chk(24'(rdiv_latch.ref_count), 24'(sh[1][15:2]), "reference count");
            chk(24'(prescaler_mode), 24'(sh[0][23:22]), "prescaler");
            chk(24'(pump_gain_eff), 24'(sh_pg), "pump gain");
        end
        // Asynchronous power-down and its forced state
        u_pllp_host_model.send_word(24'h100000);
        wait_pd(1'b1, 2);
        chk({20'h0, divider_hold, pump_tristate, rf_bias_enable, ref_buffer_enable}, 24'hc, "down state");
        repeat (2) @(posedge clk_sys);
        #1;
        chk(24'(ldc_cnt), 24'h1, "lock detect cleared");
        u_pllp_host_model.send_word(24'h000105);
        chk(rdiv_latch, 24'h000105, "load while down");
        b = bss_cnt;
        u_pllp_host_model.send_word(24'h8f0000);
        wait_pd(1'b0, 3);
        repeat (2) @(posedge clk_sys);
        #1;
        chk(24'(bss_cnt - b), 24'h0, "band kept");
        // Synchronous power-down waits for the second reference rise
        u_pllp_host_model.send_word(24'h300000);
        repeat (4) @(posedge clk_sys);
        #1;
        ref_pulse();
        repeat (3) @(posedge clk_sys);
        #1;
        chk({23'h0, powered_down}, 24'h0, "one reference rise");
        ref_pulse();
        wait_pd(1'b1, 3);
        repeat (2) @(posedge clk_sys);
        #1;
        chk(24'(ldc_cnt), 24'h2, "lock detect cleared again");
        // A feedback write while down must trigger a new band selection on wake
        u_pllp_host_model.send_word(24'h000a02);
        chk(ndiv_latch, 24'h000a02, "feedback load while down");
        u_pllp_host_model.send_word(24'h8f0000);
        wait_pd(1'b0, 3);
        repeat (2) @(posedge clk_sys);
        #1;
        chk(24'(bss_cnt - b), 24'h1, "band reselected");
        // Hardware disable overrides cleared power-down bits
        chip_enable = 1'b0;
        wait_pd(1'b1, 2);
        chip_enable = 1'b1;
        wait_pd(1'b0, 3);
        repeat (2) @(posedge clk_sys);
        #1;
        chk(24'(ldc_cnt), 24'h3, "lock detect cleared by chip enable");
        chk(24'(bss_cnt - b), 24'h1, "band kept after hardware power-down");
        // Clock enable low freezes the link; high again resumes it
        clk_en = 1'b0;
        u_pllp_host_model.send_word(24'h0000a5);
        chk(rdiv_latch, 24'h000105, "frozen while clock enable low");
        clk_en = 1'b1;
        u_pllp_host_model.send_word(24'h000205);
        chk(rdiv_latch, 24'h000205, "load after clock enable returns");
        tally_and_finish();
    end
endmodule : testbench
